// ---- bcs_defines.svh ----
// Constants for the battery charge sequencer: clock rate, safety times,
// comparator bundle width and counter width.
// Assumes the includer needs only these macros; it holds no logic.
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH

// =====================================================================
// Clock
// =====================================================================
`define BCS_CLK_HZ            64'd40000000

// =====================================================================
// Safety and dwell times, in their own units
// =====================================================================
`define BCS_PREQUAL_TIMEOUT_S 64'd1800
`define BCS_FAST_TIMEOUT_S    64'd21600
`define BCS_TOPOFF_DURATION_S 64'd600
`define BCS_TERM_DWELL_MS     64'd100

// =====================================================================
// Derived cycle counts
// =====================================================================
`define BCS_PREQUAL_CYCLES    (`BCS_PREQUAL_TIMEOUT_S * `BCS_CLK_HZ)
`define BCS_FAST_CYCLES       (`BCS_FAST_TIMEOUT_S * `BCS_CLK_HZ)
`define BCS_TOPOFF_CYCLES     (`BCS_TOPOFF_DURATION_S * `BCS_CLK_HZ)
`define BCS_DWELL_CYCLES      ((`BCS_TERM_DWELL_MS * `BCS_CLK_HZ) / 64'd1000)

// =====================================================================
// Widths
// =====================================================================
`define BCS_TIMER_W           40
`define BCS_CMP_W             11

`endif

// ---- bcs_pkg.sv ----
// Types shared by the battery charge sequencer and its test bench.
// Assumes bcs_defines.svh is available on the include path.
`include "bcs_defines.svh"

package bcs_pkg;

    // =================================================================
    // Sequencer states
    // =================================================================
    typedef enum logic [3:0] {
        BCS_IDLE,
        BCS_BUCK,
        BCS_PRECHARGE,
        BCS_TRICKLE,
        BCS_FAST_CC,
        BCS_FAST_CV,
        BCS_TOPOFF,
        BCS_DONE,
        BCS_TIMER_FAULT,
        BCS_THERMAL_SHDN
    } bcs_state_t;

    // =================================================================
    // Charge target selection for the analog loops
    // =================================================================
    typedef enum logic [2:0] {
        BCS_TGT_ZERO,
        BCS_TGT_PRECHARGE,
        BCS_TGT_TRICKLE,
        BCS_TGT_FAST,
        BCS_TGT_REG_HOLD
    } bcs_target_t;

    // =================================================================
    // Comparator and pin levels, one bundle
    // =================================================================
    typedef struct packed {
        logic input_valid;
        logic timer_suspend;
        logic thm_above_enable;
        logic above_precharge;
        logic above_trickle;
        logic above_regulation;
        logic below_restart;
        logic below_topoff_current;
        logic die_above_reg_temp;
        logic die_above_shutdown;
        logic supplement_mode;
    } bcs_cmp_t;

endpackage

// ---- bcs_sync.sv ----
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence is kept.
`timescale 1ns/1ps

module bcs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             SYS_CLK,
    input  wire logic             RESET_N,
    // Levels
    input  wire logic [WIDTH-1:0] ASYNC_IN,
    output logic      [WIDTH-1:0] SYNC_OUT
);

    // =================================================================
    // One chain per bit
    // =================================================================
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_ff;
            logic stable_ff;
            always_ff @(posedge SYS_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    meta_ff   <= 1'b0;
                    stable_ff <= 1'b0;
                end else begin
                    meta_ff   <= ASYNC_IN[i];
                    stable_ff <= meta_ff;
                end
            end
            assign SYNC_OUT[i] = stable_ff;
        end
    endgenerate

endmodule // bcs_sync

// ---- bcs_charge_fsm.sv ----
// Charge sequencer for a single-cell charger: states, safety timers,
// charge target selection and the two status pins.
// Assumes comparator levels arrive asynchronously and the analog loops
// act on the target code; the iron-phosphate strap is static.
//
// Summary of operation
// - Input invalid or timer suspended forces idle
// - Idle: zero current, safety timer held cleared
// - Idle exits only with valid input, or to overtemperature shutdown
// - Thermistor pin low with valid input: buck, except from timer fault or thermal shutdown
// - Thermistor pin high again leaves buck
// - Below precharge threshold: precharge current target
// - Li-ion: precharge to trickle above threshold
// - Prequal timeout in precharge/trickle: timer fault
// - Trickle only for Li-ion, trickle current
// - Trickle to constant current above trickle threshold
// - Iron-phosphate skips trickle into constant current, or constant voltage if above regulation
// - Constant current to voltage; fast timeout faults
// - Die over regulation temperature reduces fast current
// - System load outranks battery charge current
// - Constant voltage holds; dwell below top-off ends
// - Top-off entered only from constant voltage
// - Top-off duration elapsed: done
// - Top-off below restart level: constant current
// - Timer fault: charge off, status released
// - Overtemperature shutdown from any state
// - Done: zero current, restart to constant current
`timescale 1ns/1ps
`include "bcs_defines.svh"

module bcs_charge_fsm #(
    parameter logic [`BCS_TIMER_W-1:0] PREQUAL_CYCLES = `BCS_TIMER_W'(`BCS_PREQUAL_CYCLES),
    parameter logic [`BCS_TIMER_W-1:0] FAST_CYCLES    = `BCS_TIMER_W'(`BCS_FAST_CYCLES),
    parameter logic [`BCS_TIMER_W-1:0] TOPOFF_CYCLES  = `BCS_TIMER_W'(`BCS_TOPOFF_CYCLES),
    parameter logic [`BCS_TIMER_W-1:0] DWELL_CYCLES   = `BCS_TIMER_W'(`BCS_DWELL_CYCLES)
) (
    // Clock and reset
    input  wire logic          SYS_CLK,
    input  wire logic          RESET_N,
    // Comparator levels, asynchronous
    input  wire logic          ADAPTER_INPUT_VALID,
    input  wire logic          TIMER_SUSPEND,
    input  wire logic          THERMISTOR_PIN_HIGH,
    input  wire logic          VBATT_ABOVE_PRECHARGE,
    input  wire logic          VBATT_ABOVE_TRICKLE,
    input  wire logic          VBATT_ABOVE_REGULATION,
    input  wire logic          VBATT_BELOW_RESTART,
    input  wire logic          ICHG_BELOW_TOPOFF,
    input  wire logic          DIE_ABOVE_REG_TEMP,
    input  wire logic          DIE_ABOVE_SHUTDOWN,
    input  wire logic          SUPPLEMENT_MODE,
    // Variant strap
    input  wire logic          IRON_PHOSPHATE,
    // Analog loop controls
    output bcs_pkg::bcs_target_t CHARGE_TARGET,
    output logic               CHARGE_ENABLE,
    output logic               FAST_CURRENT_REDUCE,
    output logic               BATTERY_SYSTEM_SWITCH,
    output bcs_pkg::bcs_state_t CHARGER_STATE,
    // Open-drain status pins
    output logic               STATUS_OUT,
    output logic               STATUS_OE,
    output logic               INPUT_GOOD_N_OUT,
    output logic               INPUT_GOOD_N_OE
);

    // =================================================================
    // Input synchronisation
    // =================================================================
    bcs_pkg::bcs_cmp_t cmp_raw;
    bcs_pkg::bcs_cmp_t cmp;
    logic              lfp_sync;

    assign cmp_raw = '{
        input_valid:          ADAPTER_INPUT_VALID,
        timer_suspend:        TIMER_SUSPEND,
        thm_above_enable:     THERMISTOR_PIN_HIGH,
        above_precharge:      VBATT_ABOVE_PRECHARGE,
        above_trickle:        VBATT_ABOVE_TRICKLE,
        above_regulation:     VBATT_ABOVE_REGULATION,
        below_restart:        VBATT_BELOW_RESTART,
        below_topoff_current: ICHG_BELOW_TOPOFF,
        die_above_reg_temp:   DIE_ABOVE_REG_TEMP,
        die_above_shutdown:   DIE_ABOVE_SHUTDOWN,
        supplement_mode:      SUPPLEMENT_MODE
    };

    bcs_sync #(
        .WIDTH (`BCS_CMP_W + 1)
    ) u_sync (
        .SYS_CLK  (SYS_CLK),
        .RESET_N  (RESET_N),
        .ASYNC_IN ({cmp_raw, IRON_PHOSPHATE}),
        .SYNC_OUT ({cmp, lfp_sync})
    );

    // =================================================================
    // Decoding helpers
    // =================================================================
    function automatic logic is_charging(bcs_pkg::bcs_state_t s);
        is_charging = (s == bcs_pkg::BCS_PRECHARGE) || (s == bcs_pkg::BCS_TRICKLE) ||
                      (s == bcs_pkg::BCS_FAST_CC) || (s == bcs_pkg::BCS_FAST_CV) ||
                      (s == bcs_pkg::BCS_TOPOFF);
    endfunction

    function automatic logic [`BCS_TIMER_W-1:0] limit_for(bcs_pkg::bcs_state_t s);
        case (s)
            bcs_pkg::BCS_PRECHARGE,
            bcs_pkg::BCS_TRICKLE: limit_for = PREQUAL_CYCLES;
            bcs_pkg::BCS_FAST_CC,
            bcs_pkg::BCS_FAST_CV: limit_for = FAST_CYCLES;
            bcs_pkg::BCS_TOPOFF:  limit_for = TOPOFF_CYCLES;
            default:              limit_for = '1;
        endcase
    endfunction

    // =================================================================
    // State and timers
    // =================================================================
    bcs_pkg::bcs_state_t         state_ff;
    bcs_pkg::bcs_state_t         nxt_state;
    logic [`BCS_TIMER_W-1:0]     timer_ff;
    logic [`BCS_TIMER_W-1:0]     nxt_timer;
    logic [`BCS_TIMER_W-1:0]     dwell_ff;
    logic [`BCS_TIMER_W-1:0]     nxt_dwell;
    logic                        expired;
    logic                        dwell_done;
    logic                        force_idle;
    logic                        want_buck;

    always_comb begin
        expired    = (timer_ff >= limit_for(state_ff) - `BCS_TIMER_W'(1));
        dwell_done = cmp.below_topoff_current && (dwell_ff >= DWELL_CYCLES - `BCS_TIMER_W'(1));
        force_idle = !cmp.input_valid || cmp.timer_suspend;
        want_buck  = cmp.input_valid && !cmp.thm_above_enable &&
                     (state_ff != bcs_pkg::BCS_TIMER_FAULT);
        nxt_state  = state_ff;
        case (state_ff)
            bcs_pkg::BCS_IDLE: begin
                if (cmp.input_valid) begin
                    nxt_state = bcs_pkg::BCS_PRECHARGE;
                end
            end
            bcs_pkg::BCS_BUCK: begin
                if (cmp.thm_above_enable) begin
                    nxt_state = bcs_pkg::BCS_PRECHARGE;
                end
            end
            bcs_pkg::BCS_PRECHARGE: begin
                if (expired) begin
                    nxt_state = bcs_pkg::BCS_TIMER_FAULT;
                end else if (cmp.above_precharge && lfp_sync) begin
                    nxt_state = cmp.above_regulation ? bcs_pkg::BCS_FAST_CV
                                                     : bcs_pkg::BCS_FAST_CC;
                end else if (cmp.above_precharge) begin
                    nxt_state = bcs_pkg::BCS_TRICKLE;
                end
            end
            bcs_pkg::BCS_TRICKLE: begin
                if (expired) begin
                    nxt_state = bcs_pkg::BCS_TIMER_FAULT;
                end else if (cmp.above_trickle) begin
                    nxt_state = bcs_pkg::BCS_FAST_CC;
                end
            end
            bcs_pkg::BCS_FAST_CC: begin
                if (expired) begin
                    nxt_state = bcs_pkg::BCS_TIMER_FAULT;
                end else if (cmp.above_regulation) begin
                    nxt_state = bcs_pkg::BCS_FAST_CV;
                end
            end
            bcs_pkg::BCS_FAST_CV: begin
                if (expired) begin
                    nxt_state = bcs_pkg::BCS_TIMER_FAULT;
                end else if (dwell_done) begin
                    nxt_state = bcs_pkg::BCS_TOPOFF;
                end
            end
            bcs_pkg::BCS_TOPOFF: begin
                if (cmp.below_restart) begin
                    nxt_state = bcs_pkg::BCS_FAST_CC;
                end else if (expired) begin
                    nxt_state = bcs_pkg::BCS_DONE;
                end
            end
            bcs_pkg::BCS_DONE: begin
                if (cmp.below_restart) begin
                    nxt_state = bcs_pkg::BCS_FAST_CC;
                end
            end
            bcs_pkg::BCS_TIMER_FAULT: begin
                nxt_state = bcs_pkg::BCS_TIMER_FAULT;
            end
            bcs_pkg::BCS_THERMAL_SHDN: begin
                if (!cmp.die_above_shutdown) begin
                    nxt_state = bcs_pkg::BCS_IDLE;
                end
            end
            default: nxt_state = bcs_pkg::BCS_IDLE;
        endcase
        // Overrides, highest priority last
        if (state_ff != bcs_pkg::BCS_THERMAL_SHDN && want_buck && !force_idle) begin
            nxt_state = bcs_pkg::BCS_BUCK;
        end
        if (state_ff != bcs_pkg::BCS_THERMAL_SHDN && force_idle) begin
            nxt_state = bcs_pkg::BCS_IDLE;
        end
        if (cmp.die_above_shutdown) begin
            nxt_state = bcs_pkg::BCS_THERMAL_SHDN;
        end
        // Safety timer restarts on entry; CC to CV keeps the fast count
        if (nxt_state == bcs_pkg::BCS_IDLE) begin
            nxt_timer = '0;
        end else if (nxt_state != state_ff &&
                     !(state_ff == bcs_pkg::BCS_FAST_CC && nxt_state == bcs_pkg::BCS_FAST_CV)) begin
            nxt_timer = '0;
        end else if (expired) begin
            nxt_timer = timer_ff;
        end else begin
            nxt_timer = timer_ff + `BCS_TIMER_W'(1);
        end
        // Termination dwell must be continuous
        if (state_ff == bcs_pkg::BCS_FAST_CV && nxt_state == bcs_pkg::BCS_FAST_CV &&
            cmp.below_topoff_current) begin
            nxt_dwell = dwell_ff + `BCS_TIMER_W'(1);
        end else begin
            nxt_dwell = '0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_ff <= bcs_pkg::BCS_IDLE;
            timer_ff <= '0;
            dwell_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
            dwell_ff <= nxt_dwell;
        end
    end

    // =================================================================
    // Outputs, registered from the next state and the synchronised comparator levels
    // =================================================================
    bcs_pkg::bcs_target_t target_ff;
    bcs_pkg::bcs_target_t nxt_target;
    logic                 chg_en_ff;
    logic                 nxt_chg_en;
    logic                 reduce_ff;
    logic                 nxt_reduce;
    logic                 bat_sw_ff;
    logic                 nxt_bat_sw;
    logic                 stat_oe_ff;
    logic                 nxt_stat_oe;
    logic                 inok_oe_ff;
    logic                 nxt_inok_oe;

    always_comb begin
        case (nxt_state)
            bcs_pkg::BCS_PRECHARGE: nxt_target = bcs_pkg::BCS_TGT_PRECHARGE;
            bcs_pkg::BCS_TRICKLE:   nxt_target = bcs_pkg::BCS_TGT_TRICKLE;
            bcs_pkg::BCS_FAST_CC:   nxt_target = bcs_pkg::BCS_TGT_FAST;
            bcs_pkg::BCS_FAST_CV,
            bcs_pkg::BCS_TOPOFF:    nxt_target = bcs_pkg::BCS_TGT_REG_HOLD;
            default:                nxt_target = bcs_pkg::BCS_TGT_ZERO;
        endcase
        // Target is a ceiling; the loops serve the system load first
        nxt_chg_en  = is_charging(nxt_state);
        nxt_reduce  = cmp.die_above_reg_temp && (nxt_state == bcs_pkg::BCS_FAST_CC ||
                                                 nxt_state == bcs_pkg::BCS_FAST_CV);
        nxt_bat_sw  = is_charging(nxt_state) || (nxt_state == bcs_pkg::BCS_IDLE) ||
                      cmp.supplement_mode;
        nxt_stat_oe = is_charging(nxt_state);
        nxt_inok_oe = cmp.input_valid;
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            target_ff  <= bcs_pkg::BCS_TGT_ZERO;
            chg_en_ff  <= 1'b0;
            reduce_ff  <= 1'b0;
            bat_sw_ff  <= 1'b0;
            stat_oe_ff <= 1'b0;
            inok_oe_ff <= 1'b0;
        end else begin
            target_ff  <= nxt_target;
            chg_en_ff  <= nxt_chg_en;
            reduce_ff  <= nxt_reduce;
            bat_sw_ff  <= nxt_bat_sw;
            stat_oe_ff <= nxt_stat_oe;
            inok_oe_ff <= nxt_inok_oe;
        end
    end

    assign CHARGE_TARGET         = target_ff;
    assign CHARGE_ENABLE         = chg_en_ff;
    assign FAST_CURRENT_REDUCE   = reduce_ff;
    assign BATTERY_SYSTEM_SWITCH = bat_sw_ff;
    assign CHARGER_STATE         = state_ff;
    assign STATUS_OUT            = 1'b0;
    assign STATUS_OE             = stat_oe_ff;
    assign INPUT_GOOD_N_OUT      = 1'b0;
    assign INPUT_GOOD_N_OE       = inok_oe_ff;

    // =================================================================
    // Assertions
    // =================================================================
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    a_shutdown_entry: assert property (cmp.die_above_shutdown |=>
        state_ff == bcs_pkg::BCS_THERMAL_SHDN && !CHARGE_ENABLE)
        else $error("overtemperature did not force shutdown");

    a_idle_forced: assert property (
        state_ff != bcs_pkg::BCS_THERMAL_SHDN && !cmp.die_above_shutdown && !cmp.input_valid
        |=> state_ff == bcs_pkg::BCS_IDLE)
        else $error("invalid input did not force idle");

    a_idle_zero: assert property (state_ff == bcs_pkg::BCS_IDLE |->
        timer_ff == '0 && CHARGE_TARGET == bcs_pkg::BCS_TGT_ZERO)
        else $error("idle with current or running timer");

    a_idle_stay: assert property (state_ff == bcs_pkg::BCS_IDLE && !cmp.input_valid |=>
        state_ff inside {bcs_pkg::BCS_IDLE, bcs_pkg::BCS_THERMAL_SHDN})
        else $error("left idle without valid input");

    a_buck_entry: assert property (
        want_buck && !force_idle && !cmp.die_above_shutdown &&
        state_ff != bcs_pkg::BCS_THERMAL_SHDN
        |=> state_ff == bcs_pkg::BCS_BUCK && !CHARGE_ENABLE)
        else $error("thermistor low did not disable charging");

    a_buck_exit: assert property (
        state_ff == bcs_pkg::BCS_BUCK && cmp.thm_above_enable && !force_idle &&
        !cmp.die_above_shutdown |=> state_ff == bcs_pkg::BCS_PRECHARGE)
        else $error("buck not left when thermistor high");

    a_lfp_skip: assert property (lfp_sync |-> state_ff != bcs_pkg::BCS_TRICKLE)
        else $error("iron-phosphate variant entered trickle");

    a_topoff_source: assert property (
        state_ff == bcs_pkg::BCS_TOPOFF && $past(state_ff) != bcs_pkg::BCS_TOPOFF
        |-> $past(state_ff) == bcs_pkg::BCS_FAST_CV)
        else $error("top-off entered from wrong state");

    a_fault_release: assert property (state_ff == bcs_pkg::BCS_TIMER_FAULT |->
        !STATUS_OE && !CHARGE_ENABLE && CHARGE_TARGET == bcs_pkg::BCS_TGT_ZERO)
        else $error("timer fault with status driven or charging");

    a_prequal_timeout: assert property (
        state_ff inside {bcs_pkg::BCS_PRECHARGE, bcs_pkg::BCS_TRICKLE} &&
        timer_ff == PREQUAL_CYCLES - `BCS_TIMER_W'(1) && !force_idle && !want_buck &&
        !cmp.die_above_shutdown |=> state_ff == bcs_pkg::BCS_TIMER_FAULT)
        else $error("prequal timeout missed");

    a_done_restart: assert property (
        state_ff == bcs_pkg::BCS_DONE && cmp.below_restart && !force_idle && !want_buck &&
        !cmp.die_above_shutdown |=> state_ff == bcs_pkg::BCS_FAST_CC)
        else $error("done did not restart");

endmodule // bcs_charge_fsm

// ---- bcs_cell_model.sv ----
// Far-side model: battery level to comparator levels, host thermistor pull.
// Assumes the bench sets the battery level and the host request directly.
`timescale 1ns/1ps

module bcs_cell_model (
    // Battery level, 0 empty to 3 at regulation
    input  wire logic [1:0] LEVEL,
    // Host request and input good seen by the host
    input  wire logic       HOST_THM_LOW,
    input  wire logic       INPUT_GOOD_N_OE,
    // Comparator and pin levels
    output logic            ABOVE_PRECHARGE,
    output logic            ABOVE_TRICKLE,
    output logic            ABOVE_REGULATION,
    output logic            THM_HIGH
);
    assign ABOVE_PRECHARGE  = (LEVEL >= 2'h1);
    assign ABOVE_TRICKLE    = (LEVEL >= 2'h2);
    assign ABOVE_REGULATION = (LEVEL == 2'h3);
    // Host pulls the pin only once input good shows; otherwise the pull-up wins
    assign THM_HIGH = !(HOST_THM_LOW && INPUT_GOOD_N_OE);
endmodule // bcs_cell_model

// ---- battery_charge_state_machine_test.sv ----
// Self-checking bench for the charge sequencer: state walk, timers, buck.
// Assumes short timer parameters; the monitor compares each state change.
`timescale 1ns/1ps

module battery_charge_state_machine_test;
    logic sys_clk = 1'b0, reset_n = 1'b0, valid = 1'b0, susp = 1'b0, thm_req = 1'b0;
    logic restart = 1'b0, low_i = 1'b0, die_hot = 1'b0, shdn = 1'b0, supp = 1'b0, iron = 1'b0;
    logic [1:0] level = 2'h0;
    logic [16:0] lfsr = 17'h120cd;
    logic abv_p, abv_t, abv_r, thermistor_pin, en, red, sw, s_out, s_oe, g_out, g_oe;
    bcs_pkg::bcs_target_t tgt;
    bcs_pkg::bcs_state_t st, last_st, exp_q[$];
    int n_mismatch = 0, n_checks = 0, cycles = 0, span = 0, t_enter = 0;
    logic [2:0] supp_hist = 3'h0;

    bcs_cell_model cell_u (.LEVEL(level), .HOST_THM_LOW(thm_req), .INPUT_GOOD_N_OE(g_oe),
        .ABOVE_PRECHARGE(abv_p), .ABOVE_TRICKLE(abv_t), .ABOVE_REGULATION(abv_r), .THM_HIGH(thermistor_pin));
    bcs_charge_fsm #(.PREQUAL_CYCLES(40'd20), .FAST_CYCLES(40'd40), .TOPOFF_CYCLES(40'd16),
        .DWELL_CYCLES(40'd4)) dut_u (.SYS_CLK(sys_clk), .RESET_N(reset_n), .ADAPTER_INPUT_VALID(valid),
        .TIMER_SUSPEND(susp), .THERMISTOR_PIN_HIGH(thermistor_pin), .VBATT_ABOVE_PRECHARGE(abv_p),
        .VBATT_ABOVE_TRICKLE(abv_t), .VBATT_ABOVE_REGULATION(abv_r), .VBATT_BELOW_RESTART(restart),
        .ICHG_BELOW_TOPOFF(low_i), .DIE_ABOVE_REG_TEMP(die_hot), .DIE_ABOVE_SHUTDOWN(shdn),
        .SUPPLEMENT_MODE(supp), .IRON_PHOSPHATE(iron), .CHARGE_TARGET(tgt), .CHARGE_ENABLE(en),
        .FAST_CURRENT_REDUCE(red), .BATTERY_SYSTEM_SWITCH(sw), .CHARGER_STATE(st), .STATUS_OUT(s_out),
        .STATUS_OE(s_oe), .INPUT_GOOD_N_OUT(g_out), .INPUT_GOOD_N_OE(g_oe));

    always #12.5 sys_clk = ~sys_clk;

    function automatic logic [16:0] lfsr_next(input logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Note the next state, then wait a bounded time for the monitor to take it
    task automatic go(input bcs_pkg::bcs_state_t e);
        int i;
        exp_q.push_back(e);
        for (i = 0; i < 100 && exp_q.size() != 0; i++) @(negedge sys_clk);
        if (exp_q.size() != 0) check(8'h00, 8'hee);
        repeat (2) @(negedge sys_clk);
    endtask

    // Random supplement requests; they only steer the battery switch
    always @(negedge sys_clk) begin
        lfsr <= lfsr_next(lfsr);
        supp <= lfsr[0];
    end

    always @(negedge sys_clk) begin
        if (reset_n && st !== last_st) begin
            span = cycles - t_enter;
            t_enter = cycles;
            if (exp_q.size() == 0) check(st, 8'hff);
            else check(st, exp_q.pop_front());
        end
        last_st = st;
    end

    always @(posedge sys_clk) begin
        cycles++;
        supp_hist <= {supp_hist[1:0], supp};
        if (cycles == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (20) @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        check({tgt, en}, {bcs_pkg::BCS_TGT_ZERO, 1'b0});
        valid = 1'b1;
        go(bcs_pkg::BCS_PRECHARGE);
        check(tgt, bcs_pkg::BCS_TGT_PRECHARGE);
        check({en, sw, s_oe, g_oe, s_out, g_out}, 6'b111100);
        go(bcs_pkg::BCS_TIMER_FAULT);
        check(8'(span), 8'd20);
        check({en, s_oe}, 2'b00);
        valid = 1'b0;
        go(bcs_pkg::BCS_IDLE);
        valid = 1'b1;
        go(bcs_pkg::BCS_PRECHARGE);
        level = 2'h1;
        go(bcs_pkg::BCS_TRICKLE);
        check(tgt, bcs_pkg::BCS_TGT_TRICKLE);
        level = 2'h2;
        go(bcs_pkg::BCS_FAST_CC);
        die_hot = 1'b1;
        repeat (4) @(negedge sys_clk);
        check({tgt, red}, {bcs_pkg::BCS_TGT_FAST, 1'b1});
        die_hot = 1'b0;
        level = 2'h3;
        go(bcs_pkg::BCS_FAST_CV);
        check({tgt, red}, {bcs_pkg::BCS_TGT_REG_HOLD, 1'b0});
        low_i = 1'b1;
        go(bcs_pkg::BCS_TOPOFF);
        restart = 1'b1;
        low_i = 1'b0;
        exp_q.push_back(bcs_pkg::BCS_FAST_CC);
        go(bcs_pkg::BCS_FAST_CV);
        restart = 1'b0;
        low_i = 1'b1;
        exp_q.push_back(bcs_pkg::BCS_TOPOFF);
        go(bcs_pkg::BCS_DONE);
        check(8'(span), 8'd16);
        check(tgt, bcs_pkg::BCS_TGT_ZERO);
        restart = 1'b1;
        low_i = 1'b0;
        exp_q.push_back(bcs_pkg::BCS_FAST_CC);
        go(bcs_pkg::BCS_FAST_CV);
        restart = 1'b0;
        go(bcs_pkg::BCS_TIMER_FAULT);
        check(8'(span), 8'd39);
        thm_req = 1'b1;
        level = 2'h0;
        valid = 1'b0;
        go(bcs_pkg::BCS_IDLE);
        valid = 1'b1;
        exp_q.push_back(bcs_pkg::BCS_PRECHARGE);
        go(bcs_pkg::BCS_BUCK);
        check({sw, en}, {supp_hist[2], 1'b0});
        thm_req = 1'b0;
        go(bcs_pkg::BCS_PRECHARGE);
        shdn = 1'b1;
        go(bcs_pkg::BCS_THERMAL_SHDN);
        check(en, 1'b0);
        susp = 1'b1;
        repeat (6) @(negedge sys_clk);
        shdn = 1'b0;
        go(bcs_pkg::BCS_IDLE);
        susp = 1'b0;
        go(bcs_pkg::BCS_PRECHARGE);
        susp = 1'b1;
        go(bcs_pkg::BCS_IDLE);
        reset_n = 1'b0;
        iron = 1'b1;
        susp = 1'b0;
        level = 2'h2;
        repeat (3) @(negedge sys_clk);
        reset_n = 1'b1;
        exp_q.push_back(bcs_pkg::BCS_PRECHARGE);
        go(bcs_pkg::BCS_FAST_CC);
        tally_and_finish();
    end
endmodule // battery_charge_state_machine_test
